/* File: rtl/itvc_core.sv */
// trigger type, vector configuration and vector readback of the interrupt controller

// Behaviour
// - trigger bit 0 makes a source level sensitive, 1 makes it edge sensitive
// - external requests use bits 25 to 31 freely; bits 19 to 24 reserved
// - write-only vector configuration at 0x0C8: base in 0:29, order in 31
// - order 0 favours status position 0, order 1 favours position 31
// - vectors are generated only for critical-class sources
// - read-only vector register at 0x0C7; writes to it do nothing
module itvc_core
    import itvc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // device control register bus
    input  wire logic [9:0]  dcr_abus_in,
    input  wire logic        dcr_read_in,
    input  wire logic        dcr_write_in,
    input  wire logic [31:0] dcr_dbus_in,
    output logic      [31:0] dcr_dbus_out,
    output logic             dcr_ack_out,
    // interrupt sources and class settings
    input  wire logic [31:0] src_req_in,
    input  wire logic [31:0] src_enable_in,
    input  wire logic [31:0] crit_select_in,
    input  wire logic [31:0] pend_clear_in,
    // toward the processor core
    output logic      [31:0] pend_flags_out,
    output logic             crit_irq_out
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0] trig;
    logic [29:0] vector_base_field;
    logic        priority_order_select;
    logic [31:0] req_prev;
    logic [31:0] vector;
    logic [31:0] next_trig;
    logic [29:0] next_vba;
    logic        next_pro;
    logic [31:0] next_pend;
    logic [31:0] next_vector;
    logic [31:0] next_dbus;
    logic        next_ack;
    logic        next_crit;
    // ---------------------------------------------------------------
    // decode and helpers
    // ---------------------------------------------------------------
    logic        hit_trig;
    logic        hit_vec;
    logic        hit_vcfg;
    logic [31:0] wr_rev;
    logic [31:0] trig_rev;
    logic [31:0] rise;
    logic [31:0] crit_pend;

    assign hit_trig  = (dcr_abus_in == ITVC_TRIG_OFF);
    assign hit_vec   = (dcr_abus_in == ITVC_VECTOR_OFF);
    assign hit_vcfg  = (dcr_abus_in == ITVC_VCFG_OFF);
    assign rise      = src_req_in & ~req_prev;
    // only critical, enabled, pending sources take part in the vector
    assign crit_pend = pend_flags_out & src_enable_in & crit_select_in;

    // source i sits at word bit 31-i in the trigger register image
    genvar g;
    generate
        for (g = 0; g < ITVC_NSRC; g++) begin : g_rev
            assign wr_rev[g]   = dcr_dbus_in[ITVC_NSRC-1-g];
            assign trig_rev[g] = trig[ITVC_NSRC-1-g];
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [4:0] win;
        logic       found;
        win         = 5'h00;
        found       = 1'b0;
        next_trig   = trig;
        next_vba    = vector_base_field;
        next_pro    = priority_order_select;
        // reserved trigger positions never hold a one
        if (dcr_write_in && hit_trig) begin
            next_trig = wr_rev & ~ITVC_TRIG_RESV;
        end
        // vector configuration; the reserved bit is dropped
        if (dcr_write_in && hit_vcfg) begin
            next_vba = dcr_dbus_in[ITVC_VBA_LSB +: ITVC_VBA_W];
            next_pro = dcr_dbus_in[ITVC_PRO_BIT];
        end
        // level follows the request, edge latches until cleared; set beats clear
        for (int i = 0; i < ITVC_NSRC; i++) begin
            if (trig[i]) begin
                next_pend[i] = rise[i] | (pend_flags_out[i] & ~pend_clear_in[i]);
            end else begin
                next_pend[i] = src_req_in[i];
            end
        end
        // pick the winning critical source under the selected ordering
        for (int i = 0; i < ITVC_NSRC; i++) begin
            if (crit_pend[i] && (priority_order_select || !found)) begin
                win   = i[4:0];
                found = 1'b1;
            end
        end
        next_vector = {vector_base_field, 2'b00} + {25'h0000000, win, 2'b00};
        next_crit   = |crit_pend;
        // bus answer: mapped addresses ack, others stay silent
        next_ack    = (dcr_read_in | dcr_write_in) & (hit_trig | hit_vec | hit_vcfg);
        next_dbus   = 32'h0000_0000;
        if (dcr_read_in && hit_trig) begin
            next_dbus = trig_rev;
        end else if (dcr_read_in && hit_vec) begin
            next_dbus = vector;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trig           <= ITVC_TRIG_RST;
            vector_base_field            <= ITVC_VBA_RST;
            priority_order_select            <= ITVC_PRO_RST;
            req_prev       <= 32'h0000_0000;
            pend_flags_out <= 32'h0000_0000;
            vector         <= 32'h0000_0000;
            crit_irq_out   <= 1'b0;
            dcr_ack_out    <= 1'b0;
            dcr_dbus_out   <= 32'h0000_0000;
        end else begin
            trig           <= next_trig;
            vector_base_field            <= next_vba;
            priority_order_select            <= next_pro;
            req_prev       <= src_req_in;
            pend_flags_out <= next_pend;
            vector         <= next_vector;
            crit_irq_out   <= next_crit;
            dcr_ack_out    <= next_ack;
            dcr_dbus_out   <= next_dbus;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence vec_read_s;
        dcr_read_in && hit_vec;
    endsequence

    sequence vec_answer_s;
        dcr_ack_out && (dcr_dbus_out == $past(vector));
    endsequence

    vector_read_a : assert property (vec_read_s |=> vec_answer_s)
        else $error("vector read returned wrong data or no ack");

    vector_ro_a : assert property (dcr_write_in && hit_vec |=> $stable(trig) && $stable(vector_base_field))
        else $error("write to vector register changed state");

    vcfg_write_a : assert property (dcr_write_in && hit_vcfg
        |=> vector_base_field == $past(dcr_dbus_in[31:2]) && priority_order_select == $past(dcr_dbus_in[0]))
        else $error("vector configuration not stored");

    trig_resv_a : assert property ((trig & ITVC_TRIG_RESV) == 32'h0000_0000)
        else $error("reserved trigger bit set");

    level_follow_a : assert property (1'b1 |=> ((pend_flags_out & ~$past(trig))
        == ($past(src_req_in) & ~$past(trig))))
        else $error("level source does not follow request");

    edge_capture_a : assert property (1'b1 |=> ((($past(rise) | ($past(pend_flags_out)
        & ~$past(pend_clear_in))) & $past(trig)) == (pend_flags_out & $past(trig))))
        else $error("edge source not latched or not cleared");

    low_first_a : assert property (!priority_order_select && crit_pend[0] |=> vector == {$past(vector_base_field), 2'b00})
        else $error("position 0 did not win with order 0");

    high_first_a : assert property (priority_order_select && crit_pend[31]
        |=> vector == ({$past(vector_base_field), 2'b00} + 32'h0000_007C))
        else $error("position 31 did not win with order 1");

    noncrit_vec_a : assert property (crit_pend == 32'h0000_0000
        |=> vector == {$past(vector_base_field), 2'b00} && !crit_irq_out)
        else $error("vector or request raised without critical source");

    unmapped_a : assert property (!(hit_trig || hit_vec || hit_vcfg) |=> !dcr_ack_out)
        else $error("ack on unmapped address");

    // a mapped strobe is answered exactly one cycle later
    sequence bus_req_s;
        (dcr_read_in || dcr_write_in) && (hit_trig || hit_vec || hit_vcfg);
    endsequence

    bus_ack_a : assert property (bus_req_s |=> dcr_ack_out)
        else $error("mapped access not acknowledged");

    // the data bus rests at zero unless a register is being read
    idle_data_a : assert property (!dcr_read_in |=> dcr_dbus_out == 32'h0000_0000)
        else $error("read data not zero outside a read");

    vcfg_wo_a : assert property (dcr_read_in && hit_vcfg
        |=> dcr_dbus_out == 32'h0000_0000)
        else $error("write-only configuration returned data");

    crit_raise_a : assert property (crit_pend != 32'h0000_0000 |=> crit_irq_out)
        else $error("critical request not raised");

    // a latched edge flag stays up until its clear arrives
    edge_hold_a : assert property (trig[25] && pend_flags_out[25] && !pend_clear_in[25]
        |=> pend_flags_out[25])
        else $error("edge flag lost before its clear");
endmodule : itvc_core

/* File: rtl/itvc_pkg.sv */
// constants shared by the trigger and vector configuration block
package itvc_pkg;
    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int          ITVC_ADDR_W      = 10;
    localparam int          ITVC_DATA_W      = 32;
    localparam int          ITVC_NSRC        = 32;
    localparam int          ITVC_IDX_W       = 5;
    // ---------------------------------------------------------------
    // register offsets on the device control register bus
    // ---------------------------------------------------------------
    localparam logic [9:0]  ITVC_TRIG_OFF    = 10'h0C5;
    localparam logic [9:0]  ITVC_VECTOR_OFF  = 10'h0C7;
    localparam logic [9:0]  ITVC_VCFG_OFF    = 10'h0C8;
    // ---------------------------------------------------------------
    // field layout; word bit 31 is documented bit 0
    // ---------------------------------------------------------------
    localparam int          ITVC_PRO_BIT     = 0;
    localparam int          ITVC_VBA_LSB     = 2;
    localparam int          ITVC_VBA_W       = 30;
    // sources 19..24 have no trigger bit
    localparam logic [31:0] ITVC_TRIG_RESV   = 32'h01F8_0000;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] ITVC_TRIG_RST    = 32'h0000_0000;
    localparam logic [29:0] ITVC_VBA_RST     = 30'h0000_0000;
    localparam logic        ITVC_PRO_RST     = 1'b0;
endpackage : itvc_pkg

/* File: dv/itvc_src_model.sv */
// model of the peripheral and external request lines feeding the block
module itvc_src_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // commands from the bench
    input  wire logic [31:0] level_in,
    input  wire logic [31:0] pulse_in,
    // request lines toward the block
    output logic      [31:0] src_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // a pulse command lasts one cycle, so an edge source sees one rise
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_req_out <= 32'h0000_0000;
        end else begin
            src_req_out <= level_in | pulse_in;
        end
    end
endmodule : itvc_src_model

/* File: dv/test_interrupt_trigger_vector_cfg.sv */
// self-checking bench for the trigger and vector configuration block
module test_interrupt_trigger_vector_cfg;
    import itvc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk_in = 0, rstn_in = 0, dcr_read_in = 0, dcr_write_in = 0, dcr_ack_out, crit_irq_out;
    logic [9:0]  dcr_abus_in = 10'h000;
    logic [31:0] dcr_dbus_in = 0, dcr_dbus_out, src_req_in, pend_flags_out, q;
    logic [31:0] src_enable_in = 0, crit_select_in = 0, pend_clear_in = 0, lvl = 0, pls = 0;
    logic        k;
    int          error_cnt = 0, cmp_count = 0;
    // ---------------------------------------------------------------
    // block, source model and clock
    // ---------------------------------------------------------------
    itvc_core dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .dcr_abus_in(dcr_abus_in),
        .dcr_read_in(dcr_read_in), .dcr_write_in(dcr_write_in), .dcr_dbus_in(dcr_dbus_in),
        .dcr_dbus_out(dcr_dbus_out), .dcr_ack_out(dcr_ack_out), .src_req_in(src_req_in),
        .src_enable_in(src_enable_in), .crit_select_in(crit_select_in),
        .pend_clear_in(pend_clear_in), .pend_flags_out(pend_flags_out),
        .crit_irq_out(crit_irq_out));
    itvc_src_model src_u (.clk_in(clk_in), .rstn_in(rstn_in), .level_in(lvl),
        .pulse_in(pls), .src_req_out(src_req_in));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one register access; strobe held until ack is sampled, bounded wait
    task automatic bus(input int w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_in);
        dcr_abus_in <= a;
        dcr_write_in <= (w != 0);
        dcr_read_in <= (w == 0);
        dcr_dbus_in <= d;
        k = 1'b0;
        q = 32'h0000_0000;
        for (int n = 0; n < 4 && !k; n++) begin
            @(posedge clk_in);
            if (dcr_ack_out === 1'b1) begin
                k = 1'b1;
                q = dcr_dbus_out;
            end
        end
        dcr_read_in <= 1'b0;
        dcr_write_in <= 1'b0;
        // a mapped register that never answers ends the run
        if (!k && (a == ITVC_TRIG_OFF || a == ITVC_VECTOR_OFF || a == ITVC_VCFG_OFF)) begin
            error_cnt++;
            $display("Error at %0t: no acknowledge from address %h", $time, a);
            end_of_test();
        end
    endtask : bus
    task automatic settle();
        repeat (3) @(posedge clk_in);
    endtask : settle
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        bus(0, ITVC_VECTOR_OFF, 0);
        chk(q, 32'h0000_0000);
        bus(0, ITVC_VCFG_OFF, 0);
        chk({31'h0, k}, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        bus(0, 10'h0C9, 0);
        chk({31'h0, k}, 32'h0000_0000);
    endtask : t_reset
    task automatic t_vector();
        bus(1, ITVC_VCFG_OFF, 32'h0000_0400);
        src_enable_in <= 32'hFFFF_FFFF;
        crit_select_in <= 32'h0000_0028;
        lvl <= 32'h0000_0028;
        settle();
        bus(0, ITVC_VECTOR_OFF, 0);
        chk(q, 32'h0000_040C);
        chk({31'h0, crit_irq_out}, 32'h0000_0001);
        bus(1, ITVC_VCFG_OFF, 32'h0000_0403);
        bus(1, ITVC_VECTOR_OFF, 32'hFFFF_FFFF);
        bus(0, ITVC_VECTOR_OFF, 0);
        chk(q, 32'h0000_0414);
        crit_select_in <= 32'h0000_0000;
        settle();
        bus(0, ITVC_VECTOR_OFF, 0);
        chk({31'h0, crit_irq_out}, 32'h0000_0000);
        chk(q, 32'h0000_0400);
        chk(pend_flags_out, 32'h0000_0028);
    endtask : t_vector
    task automatic t_trigger();
        // internal sources 9..18 stay level: bits 22:13 written as 0
        bus(1, ITVC_TRIG_OFF, 32'h0000_1FFF);
        bus(0, ITVC_TRIG_OFF, 0);
        chk(q, 32'h0000_007F);
        crit_select_in <= 32'h0200_0000;
        lvl <= 32'h0000_0000;
        pls <= 32'h0200_0000;
        @(posedge clk_in);
        pls <= 32'h0000_0000;
        settle();
        chk(pend_flags_out, 32'h0200_0000);
        bus(0, ITVC_VECTOR_OFF, 0);
        chk(q, 32'h0000_0464);
        pend_clear_in <= 32'h0200_0000;
        @(posedge clk_in);
        pend_clear_in <= 32'h0000_0000;
        settle();
        chk({31'h0, crit_irq_out}, 32'h0000_0000);
        chk(pend_flags_out, 32'h0000_0000);
    endtask : t_trigger
    task automatic t_order();
        // both ends of the status word pending, every source level sensed
        bus(1, ITVC_TRIG_OFF, 32'h0000_0000);
        bus(1, ITVC_VCFG_OFF, 32'h0000_0800);
        crit_select_in <= 32'h8000_0001;
        lvl <= 32'h8000_0001;
        settle();
        bus(0, ITVC_VECTOR_OFF, 32'h0000_0000);
        chk(q, 32'h0000_0800);
        bus(1, ITVC_VCFG_OFF, 32'h0000_0801);
        bus(0, ITVC_VECTOR_OFF, 32'h0000_0000);
        chk(q, 32'h0000_087C);
        // a pending source whose enable is low takes no part
        src_enable_in <= 32'h7FFF_FFFF;
        settle();
        bus(0, ITVC_VECTOR_OFF, 32'h0000_0000);
        chk(q, 32'h0000_0800);
        lvl <= 32'h0000_0000;
        settle();
        chk(pend_flags_out, 32'h0000_0000);
    endtask : t_order
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_vector();
        t_trigger();
        t_order();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        end_of_test();
    end
endmodule : test_interrupt_trigger_vector_cfg
